// ---- ptg_port.sv ----
// port three gpio: 15 lines with data, direction, open-drain and alternate merge
// assumes single clock, synchronous active-low reset, pins resolved outside
//
// Overview of operation
// - direction bit selects input or output per line
// - open-drain per bit; lines 15,14,12 push-pull
// - data bit 14 stored, never drives pin
// - alternate inputs read synchronised pin latch
// - alternate output ANDed with data latch
// - input direction floats; cleared latch holds low
// - unused alternate output rests high
// - bidirectional alternate lines follow the direction bit
// - clock output enables line 15 driver
// - line 12 strobe active after reset
// - strobe enables line 12 driver
// - bus hold returns line 12 to port
// - alternate functions mapped to fixed lines
// - software write beats hardware latch update
`timescale 1ns/10ps
`include "ptg_params.svh"
module ptg_port (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // register port
   input  wire ptg_pkg::ptg_addr_t regAddr,
   input  wire ptg_pkg::ptg_word_t regWdata,
   input  wire logic             regWr,
   input  wire logic             regRd,
   output logic [15:0]           regRdata,
   // start-up strap and bus hold
   input  wire logic             strapWriteHigh,
   input  wire logic             busHold,
   // alternate outputs from peripherals, rest high when unused
   input  wire logic             timer_six_toggle_output,
   input  wire logic             timer_three_toggle_output,
   input  wire logic             sync_serial_master_out,
   input  wire logic             sync_serial_master_in_out,
   input  wire logic             async_transmit_line,
   input  wire logic             async_receive_line_out,
   input  wire logic             shift_clock_out,
   input  wire logic             upper_byte_strobe,
   input  wire logic             write_high_strobe,
   input  wire logic             system_clock_output,
   // hardware latch update from peripherals
   input  wire logic [15:0]      hwLatchSet,
   input  wire logic [15:0]      hwLatchVal,
   // alternate inputs to peripherals
   output logic                  timer_zero_count_input,
   output logic                  capture_input,
   output logic                  timer_three_updown_input,
   output logic                  timer_four_count_input,
   output logic                  timer_three_count_input,
   output logic                  timer_two_count_input,
   output logic                  sync_serial_master_in,
   output logic                  sync_serial_slave_in,
   output logic                  async_receive_line,
   output logic                  shift_clock_in,
   // pins
   input  wire logic [15:0]      pinIn,
   output logic [15:0]           pinOut,
   output logic [15:0]           pinOe
);
   import ptg_pkg::*;

   // ==========================================================
   // registers
   ptg_word_t dataLatch_q;
   ptg_word_t dir_q;
   ptg_word_t odc_q;
   logic      upper_byte_strobe_disable_q;
   logic      write_config_select_q;
   logic      clkOutEn_q;
   logic      strapSeen_q;
   ptg_word_t pinSync1_q;
   ptg_word_t pinSync2_q;

   function automatic logic hit(input ptg_addr_t a, input ptg_addr_t ofs);
      hit = (a == ofs);
   endfunction

   always_ff @(posedge clk) begin
      if (!rstn) begin
         dataLatch_q <= `PTG_RST_DATA;
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (regWr && hit(regAddr, `PTG_OFS_DATA)) begin
               dataLatch_q[i] <= regWdata[i];
            end else if (hwLatchSet[i]) begin
               dataLatch_q[i] <= hwLatchVal[i];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         dir_q <= `PTG_RST_DIR;
      end else if (regWr && hit(regAddr, `PTG_OFS_DIR)) begin
         dir_q <= regWdata & `PTG_DIR_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         odc_q <= `PTG_RST_ODC;
      end else if (regWr && hit(regAddr, `PTG_OFS_ODC)) begin
         odc_q <= regWdata & `PTG_ODC_MASK;
      end
   end

   // config: strobe disable, write-high select (strap at release), clock out
   always_ff @(posedge clk) begin
      if (!rstn) begin
         upper_byte_strobe_disable_q    <= 1'b0;
         write_config_select_q     <= 1'b0;
         clkOutEn_q  <= 1'b0;
         strapSeen_q <= 1'b0;
      end else begin
         strapSeen_q <= 1'b1;
         if (!strapSeen_q) begin
            write_config_select_q <= strapWriteHigh;
         end
         if (regWr && hit(regAddr, `PTG_OFS_CFG)) begin
            upper_byte_strobe_disable_q   <= regWdata[`PTG_CFG_STRB_DIS];
            write_config_select_q    <= regWdata[`PTG_CFG_WR_SEL];
            clkOutEn_q <= regWdata[`PTG_CFG_CLK_EN];
         end
      end
   end

   // ==========================================================
   // pin input latch
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pinSync1_q <= 16'h0000;
         pinSync2_q <= 16'h0000;
      end else begin
         pinSync1_q <= pinIn;
         pinSync2_q <= pinSync1_q;
      end
   end

   // ==========================================================
   // read data
   always_ff @(posedge clk) begin
      if (!rstn) begin
         regRdata <= 16'h0000;
      end else if (regRd) begin
         if (hit(regAddr, `PTG_OFS_DATA)) begin
            regRdata <= dataLatch_q;
         end else if (hit(regAddr, `PTG_OFS_DIR)) begin
            regRdata <= dir_q;
         end else if (hit(regAddr, `PTG_OFS_ODC)) begin
            regRdata <= odc_q;
         end else if (hit(regAddr, `PTG_OFS_CFG)) begin
            regRdata <= {13'h0000, clkOutEn_q, write_config_select_q, upper_byte_strobe_disable_q};
         end else begin
            regRdata <= 16'h0000;
         end
      end else begin
         regRdata <= 16'h0000;
      end
   end

   // ==========================================================
   // output merge
   logic      strobeOn;
   logic      strobeVal;
   ptg_word_t altOut;
   ptg_word_t drv;
   ptg_word_t en;

   assign strobeOn  = (!write_config_select_q && !upper_byte_strobe_disable_q) || write_config_select_q;
   assign strobeVal = write_config_select_q ? write_high_strobe : upper_byte_strobe;

   always_comb begin
      altOut = 16'hFFFF;
      altOut[`PTG_LINE_TIM6] = timer_six_toggle_output;
      altOut[`PTG_LINE_TIM3] = timer_three_toggle_output;
      altOut[`PTG_LINE_SSMI] = sync_serial_master_in_out;
      altOut[`PTG_LINE_SSMO] = sync_serial_master_out;
      altOut[`PTG_LINE_ATX]  = async_transmit_line;
      altOut[`PTG_LINE_ARX]  = async_receive_line_out;
      altOut[`PTG_LINE_SCLK] = shift_clock_out;
      drv = dataLatch_q & altOut;
      en  = dir_q;
      if (clkOutEn_q) begin
         drv[`PTG_LINE_CLK] = system_clock_output;
         en[`PTG_LINE_CLK]  = 1'b1;
      end
      if (strobeOn && !busHold) begin
         drv[`PTG_LINE_STRB] = strobeVal;
         en[`PTG_LINE_STRB]  = 1'b1;
      end else begin
         drv[`PTG_LINE_STRB] = dataLatch_q[`PTG_LINE_STRB];
         en[`PTG_LINE_STRB]  = dir_q[`PTG_LINE_STRB];
      end
      drv = drv & `PTG_PIN_MASK;
      en  = en & `PTG_PIN_MASK;
   end

   always_comb begin
      pinOut = drv;
      // open drain releases the pin on a one and actively pulls low on a zero
      pinOe  = en & ~(odc_q & drv);
   end

   // ==========================================================
   // alternate inputs
   always_comb begin
      timer_zero_count_input   = pinSync2_q[`PTG_LINE_CNT0];
      capture_input            = pinSync2_q[`PTG_LINE_CAPT];
      timer_three_updown_input = pinSync2_q[`PTG_LINE_UPDN3];
      timer_four_count_input   = pinSync2_q[`PTG_LINE_CNT4];
      timer_three_count_input  = pinSync2_q[`PTG_LINE_CNT3];
      timer_two_count_input    = pinSync2_q[`PTG_LINE_CNT2];
      sync_serial_master_in    = pinSync2_q[`PTG_LINE_SSMI];
      sync_serial_slave_in     = pinSync2_q[`PTG_LINE_SSMO];
      async_receive_line       = pinSync2_q[`PTG_LINE_ARX];
      shift_clock_in           = pinSync2_q[`PTG_LINE_SCLK];
   end
endmodule // ptg_port

// ---- ptg_params.svh ----
// port three gpio constants: register offsets, widths, masks, reset values
// assumes inclusion by bare name from the package and the port module
`ifndef PTG_PARAMS_SVH
`define PTG_PARAMS_SVH
`define PTG_ADDR_W        16
`define PTG_DATA_W        16
`define PTG_OFS_DATA      16'hFFC4
`define PTG_OFS_DIR       16'hFFC6
`define PTG_OFS_ODC       16'hF1C6
`define PTG_OFS_CFG       16'hF1C8
`define PTG_RST_DATA      16'h0000
`define PTG_RST_DIR       16'h0000
`define PTG_RST_ODC       16'h0000
`define PTG_ODC_MASK      16'h2FFF
`define PTG_DIR_MASK      16'hBFFF
`define PTG_PIN_MASK      16'hBFFF
`define PTG_ALT_OUT_MASK  16'h0E0A
`define PTG_CFG_STRB_DIS  0
`define PTG_CFG_WR_SEL    1
`define PTG_CFG_CLK_EN    2
`define PTG_LINE_CNT0     0
`define PTG_LINE_CAPT     2
`define PTG_LINE_UPDN3    4
`define PTG_LINE_CNT4     5
`define PTG_LINE_CNT3     6
`define PTG_LINE_CNT2     7
`define PTG_LINE_TIM6     1
`define PTG_LINE_TIM3     3
`define PTG_LINE_SSMI     8
`define PTG_LINE_SSMO     9
`define PTG_LINE_ATX      10
`define PTG_LINE_ARX      11
`define PTG_LINE_STRB     12
`define PTG_LINE_SCLK     13
`define PTG_LINE_CLK      15
`endif

// ---- ptg_pkg.sv ----
// port three gpio package: shared types
// assumes the constants header is on the include path
`include "ptg_params.svh"
package ptg_pkg;
   typedef logic [`PTG_DATA_W-1:0] ptg_word_t;
   typedef logic [`PTG_ADDR_W-1:0] ptg_addr_t;
endpackage

// ---- ptg_board_model.sv ----
// board model: pull-ups on every port pin and one external driver
// assumes the pin level is resolved here and fed back to the port
`timescale 1ns/10ps
module ptg_board_model (
   // port side
   input  wire logic [15:0] pinOut,
   input  wire logic [15:0] pinOe,
   // external driver
   input  wire logic [15:0] extEn,
   input  wire logic [15:0] extVal,
   // resolved level
   output logic [15:0]      pinIn
);
   // ==========
   // pin resolution, pull-up when nobody drives
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (pinOe[i]) pinIn[i] = pinOut[i];
         else if (extEn[i]) pinIn[i] = extVal[i];
         else pinIn[i] = 1'h1;
      end
   end
endmodule // ptg_board_model

// ---- ptg_port_sva.sv ----
// checker for the port three pins and register port
// assumes bind to ptg_port with ports of matching names
`timescale 1ns/10ps
module ptg_port_sva (
   // clock and reset
   input wire logic               clk,
   input wire logic               rstn,
   // register port
   input wire ptg_pkg::ptg_addr_t regAddr,
   input wire ptg_pkg::ptg_word_t regWdata,
   input wire logic               regWr,
   input wire logic               regRd,
   input wire logic [15:0]        regRdata,
   // pins and alternates
   input wire logic               busHold,
   input wire logic               timer_six_toggle_output,
   input wire logic               timer_zero_count_input,
   input wire logic [15:0]        pinIn,
   input wire logic [15:0]        pinOut,
   input wire logic [15:0]        pinOe
);
   import ptg_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic dir12_q;
   always_ff @(posedge clk) begin
      if (!rstn) dir12_q <= 1'h0;
      else if (regWr && regAddr == 16'hFFC6) dir12_q <= regWdata[12];
   end
   // ==========
   // assertions
   AST_DIR_IN: assert property (regWr && regAddr == 16'hFFC6 && !regWdata[0] |=> !pinOe[0])
      else $error("line 0 drives as input");
   AST_BIT14: assert property (!pinOe[14])
      else $error("line 14 drives");
   AST_ALT_IN: assert property ($past(rstn, 2) |-> timer_zero_count_input == $past(pinIn[0], 2))
      else $error("alternate input wrong");
   AST_AND: assert property (pinOe[1] && pinOut[1] |-> timer_six_toggle_output)
      else $error("alternate output not anded");
   AST_SYSTEM_CLOCK_OUTPUT: assert property (regWr && regAddr == 16'hF1C8 && regWdata[2] |=> pinOe[15])
      else $error("clock output not driven");
   AST_STRB: assert property ($past(!rstn) && !busHold |-> pinOe[12])
      else $error("strobe driver off after reset");
   AST_HOLD: assert property (busHold |-> pinOe[12] == dir12_q)
      else $error("line 12 not plain port in hold");
   AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 16'h0000)
      else $error("read data outside read");
   AST_ODC_RD: assert property (regRd && regAddr == 16'hF1C6 |=> regRdata[15:14] == 2'h0 && !regRdata[12])
      else $error("unsupported open drain bit reads set");
   cover property (busHold);
   cover property (pinOe[15]);
   cover property (regRd && regAddr == 16'hF1C6);
endmodule // ptg_port_sva

// ---- testbench.sv ----
// testbench for the port three gpio block
// assumes ptg_port, its checker and the board model are compiled before
`timescale 1ns/10ps
module testbench;
   import ptg_pkg::*;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   ptg_addr_t regAddr = 16'h0000;
   ptg_word_t regWdata = 16'h0000;
   logic regWr = 1'h0, regRd = 1'h0, busHold = 1'h0, t0In;
   logic [2:0] altOut = 3'h7;
   logic [15:0] hwLatchSet = 16'h0000, hwLatchVal = 16'h0000, extVal = 16'hFFFF;
   logic [15:0] regRdata, pinIn, pinOut, pinOe;
   int miscompares = 0, nCompared = 0;
   always #2 clk = ~clk;
   ptg_port dut_u (
      .clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .strapWriteHigh(1'h0), .busHold, .hwLatchSet, .hwLatchVal,
      .timer_six_toggle_output(altOut[0]), .timer_three_toggle_output(altOut[1]),
      .sync_serial_master_out(altOut[2]), .sync_serial_master_in_out(altOut[2]),
      .async_transmit_line(altOut[2]), .async_receive_line_out(altOut[2]),
      .shift_clock_out(altOut[2]), .upper_byte_strobe(altOut[2]),
      .write_high_strobe(altOut[2]), .system_clock_output(altOut[2]),
      .timer_zero_count_input(t0In), .capture_input(), .timer_three_updown_input(),
      .timer_four_count_input(), .timer_three_count_input(), .timer_two_count_input(),
      .sync_serial_master_in(), .sync_serial_slave_in(), .async_receive_line(),
      .shift_clock_in(), .pinIn, .pinOut, .pinOe);
   ptg_board_model board_u (.pinOut, .pinOe, .extEn(16'h0001), .extVal, .pinIn);
   // ==========
   // bus and compare tasks
   task automatic chk(input ptg_word_t got, input ptg_word_t exp);
      nCompared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input ptg_addr_t a, input ptg_word_t d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'h1;
      @(posedge clk);
      regWr <= 1'h0;
      #1;
   endtask
   task automatic rd(input ptg_addr_t a, input ptg_word_t exp);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge clk);
      regRd <= 1'h0;
      #1 chk(regRdata, exp);
   endtask
   task automatic test_done;
      $display("compared %0d miscompares %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ==========
   // scenarios
   task automatic t_reset;
      rd(16'hFFC4, 16'h0000);
      rd(16'hFFC6, 16'h0000);
      rd(16'hF1C6, 16'h0000);
      rd(16'h1234, 16'h0000);
      chk(pinOe, 16'h1000);
      @(posedge clk);
      busHold <= 1'h1;
      @(posedge clk);
      #1 chk(pinOe, 16'h0000);
      @(posedge clk);
      busHold <= 1'h0;
   endtask
   task automatic t_gpio;
      wr(16'hF1C8, 16'h0001);
      wr(16'hFFC4, 16'h5555);
      wr(16'hFFC6, 16'hFFFF);
      chk(pinOe, 16'hBFFF);
      chk(pinIn & pinOe, 16'h1555);
      rd(16'hFFC4, 16'h5555);
      rd(16'hFFC6, 16'hBFFF);
      wr(16'hF1C6, 16'hFFFF);
      wr(16'hFFC4, 16'hFFFF);
      chk(pinOe, 16'h9000);
      chk(pinIn, 16'hFFFF);
      rd(16'hF1C6, 16'h2FFF);
      wr(16'hF1C6, 16'h0000);
   endtask
   task automatic t_alt;
      @(posedge clk);
      altOut[0] <= 1'h0;
      @(posedge clk);
      #1 chk(pinOut & 16'h000A, 16'h0008);
      @(posedge clk);
      altOut[0] <= 1'h1;
      wr(16'hFFC4, 16'hFFF7);
      chk(pinOut & 16'h000A, 16'h0002);
      wr(16'hFFC6, 16'hFFF5);
      chk(pinOe & 16'h000A, 16'h0000);
      wr(16'hFFC6, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         extVal[0] <= i[0];
         repeat (2) @(posedge clk);
         #1 chk({15'h0000, t0In}, {15'h0000, i[0]});
      end
      wr(16'hF1C8, 16'h0005);
      chk(pinOe, 16'h8000);
   endtask
   task automatic t_hw;
      @(posedge clk);
      hwLatchSet <= 16'h0001;
      hwLatchVal <= 16'h0001;
      regAddr <= 16'hFFC4;
      regWdata <= 16'h0000;
      regWr <= 1'h1;
      @(posedge clk);
      regWr <= 1'h0;
      hwLatchSet <= 16'h0000;
      rd(16'hFFC4, 16'h0000);
      @(posedge clk);
      hwLatchSet <= 16'h0001;
      @(posedge clk);
      hwLatchSet <= 16'h0000;
      rd(16'hFFC4, 16'h0001);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'h1;
      t_reset();
      t_gpio();
      t_alt();
      t_hw();
      test_done();
   end
endmodule // testbench
bind ptg_port ptg_port_sva chk_u (.*);
